// File: tb/cclc_host_model.sv
// host controller model that issues command and data bytes to the bank
module cclc_host_model (
  // clock
  input wire logic sys_clk_in,
  // byte stream towards the bank
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  // read answer from the bank
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************
  // byte level tasks
  // ************************************
  // bus idle at time zero
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
  end
  // offer one byte just after an edge; it is taken at the next edge
  task automatic put(input logic [7:0] b);
    byte_valid_out = 1'b1;
    byte_out = b;
    @(posedge sys_clk_in);
    #1;
  endtask
  // release: inverted last byte so stale data never passes for a good one
  task automatic idle();
    byte_valid_out = 1'b0;
    byte_out = ~byte_out;
    @(posedge sys_clk_in);
    #1;
  endtask
  // write: command with the flag set, then its data byte; bus left driven
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 7'h00) v[2] = v[0];
    put({1'b1, a});
    put(v);
  endtask
  // read: one command byte, answer registered at the taking edge
  task automatic rd(input logic [6:0] a, output logic ok, output logic [7:0] d);
    put({1'b0, a});
    ok = rd_valid_in;
    d = rd_data_in;
    idle();
  endtask
endmodule

// File: tb/testbench.sv
// self-checking bench for the channel local config bank
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************
  // clock, reset and wiring
  // ************************************
  localparam logic [23:0] ONE_STEP = 24'h000004; // shortened so runs stay short
  localparam logic [23:0] TWO_STEP = 24'h000006;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic byte_valid;
  logic [7:0] byte_val;
  logic rd_valid;
  logic [7:0] rd_data;
  cclc_pkg::cclc_cfg_s cfg;
  logic [3:0] line_pins = 4'h0;
  logic [1:0] bidir_in = 2'h0;
  logic [3:0] line_level;
  logic [3:0] line_irq;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] regs [8]; // expected register image
  logic [7:0] pat [8] = '{8'h5d, 8'ha6, 8'hff, 8'hc3, 8'h12, 8'h34, 8'h56, 8'h7a};
  logic acc;
  // 40 MHz clock
  always #12.5 sys_clk_in = ~sys_clk_in;
  cclc_local_config #(.ONE_STEP_CYC(ONE_STEP), .TWO_STEP_CYC(TWO_STEP)) u_cclc_local_config (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .byte_valid_in(byte_valid), .byte_in(byte_val), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .cfg_out(cfg), .line_pins_in(line_pins),
    .bidir_as_input_in(bidir_in), .line_level_out(line_level), .line_irq_out(line_irq));
  cclc_host_model u_cclc_host_model (
    .sys_clk_in(sys_clk_in), .byte_valid_out(byte_valid), .byte_out(byte_val),
    .rd_valid_in(rd_valid), .rd_data_in(rd_data));
  // ************************************
  // checking helpers
  // ************************************
  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // settings expected on cfg_out from the register image
  function automatic cclc_pkg::cclc_cfg_s image();
    return {regs[0], regs[1], regs[2][0], regs[3], regs[5][3:0], regs[4], regs[6],
      regs[5][7:4], regs[7]};
  endfunction
  // read one register and check the one-cycle answer
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic ok;
    logic [7:0] d;
    u_cclc_host_model.rd(a, ok, d);
    chk(ok, 1'b1, "read answer");
    chk(d, exp, "read data");
    chk(rd_valid, 1'b0, "read answer length");
  endtask
  // count edges until a filtered level shows, then check the event pulse
  task automatic edges_to(input int idx, input logic lvl, input int exp, input logic irq);
    int n;
    n = 0;
    while (line_level[idx] !== lvl && n < 200) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: level wait ran out", $time);
      give_verdict();
    end else begin
      chk(n, exp, "edges to level");
      chk(line_irq[idx], irq, "event pulse");
      @(posedge sys_clk_in);
      #1;
      chk(line_irq[idx], 1'b0, "event pulse length");
    end
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    repeat (6) @(posedge sys_clk_in);
    #1;
    resetn_in = 1'b1;
    // reset values, high-pass the only set bit
    foreach (regs[i]) regs[i] = 8'h00;
    regs[0] = 8'h08;
    chk(cfg, image(), "reset settings");
    for (int i = 0; i < 8; i++) rchk(7'(i), regs[i]);
    $display("test reset values done");
    // back-to-back writes of a pattern and its inverse, all bits both ways
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] = (p == 0) ? pat[i] : ~pat[i];
        u_cclc_host_model.wr(7'(i), regs[i]);
      end
      u_cclc_host_model.idle();
      regs[2] = regs[2] & 8'h01; // reserved bits of the pcm loopback byte read zero
      chk(cfg, image(), "settings");
      for (int i = 0; i < 8; i++) rchk(7'(i), regs[i]);
    end
    $display("test write and read back done");
    // refused write: its data byte must not be taken as a command
    u_cclc_host_model.wr(7'h08, 8'hff);
    u_cclc_host_model.wr(7'h07, 8'h3c);
    regs[7] = 8'h3c;
    u_cclc_host_model.idle();
    // bytes offered while the clock enable is low are ignored
    clk_en_in = 1'b0;
    u_cclc_host_model.wr(7'h07, 8'hc5);
    u_cclc_host_model.idle();
    clk_en_in = 1'b1;
    rchk(7'h08, 8'h00);
    rchk(7'h7f, 8'h00);
    rchk(7'h07, regs[7]);
    $display("test unmapped and enable done");
    // line pins: lines 3, 2 and 0 enabled, line 1 masked, no debounce
    u_cclc_host_model.wr(7'h01, 8'hd0);
    u_cclc_host_model.wr(7'h03, 8'h00);
    u_cclc_host_model.idle();
    line_pins[3] = 1'b1;
    edges_to(3, 1'b1, 3, 1'b1);
    bidir_in = 2'h1;
    line_pins[1] = 1'b1;
    edges_to(1, 1'b1, 3, 1'b0);
    line_pins[0] = 1'b1;
    edges_to(0, 1'b1, 3, 1'b0);
    bidir_in = 2'h3;
    line_pins[0] = 1'b0;
    edges_to(0, 1'b0, 3, 1'b1);
    $display("test line events done");
    // debounce: input one code 2, input two code 1
    u_cclc_host_model.wr(7'h03, 8'h12);
    u_cclc_host_model.idle();
    line_pins[3] = 1'b0;
    edges_to(3, 1'b0, 2 + 2 * 4, 1'b1);
    line_pins[2] = 1'b1;
    edges_to(2, 1'b1, 2 + 1 * 6, 1'b1);
    // a bounce shorter than the debounce time is never accepted
    acc = 1'b0;
    line_pins[3] = 1'b1;
    for (int k = 0; k < 16; k++) begin
      if (k == 5) line_pins[3] = 1'b0;
      @(posedge sys_clk_in);
      #1;
      acc = acc | line_level[3] | line_irq[3];
    end
    chk(acc, 1'b0, "bounce accepted");
    line_pins[3] = 1'b1;
    edges_to(3, 1'b1, 2 + 2 * 4, 1'b1);
    $display("test debounce done");
    give_verdict();
  end
endmodule

// File: verilog/cclc_local_config.sv
// per-channel local configuration bank with command-byte access
module cclc_local_config #(
  parameter logic [23:0] ONE_STEP_CYC = 24'(cclc_pkg::DEB_ONE_STEP_CYC),
  parameter logic [23:0] TWO_STEP_CYC = 24'(cclc_pkg::DEB_TWO_STEP_CYC)
) (
  // clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // command byte stream from the host interface
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // read answer
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  // settings to the channel datapath
  output cclc_pkg::cclc_cfg_s cfg_out,
  // line-interface pins, asynchronous
  input wire logic [3:0] line_pins_in,
  input wire logic [1:0] bidir_as_input_in,
  // filtered line levels and interrupt events
  output logic [3:0] line_level_out,
  output logic [3:0] line_irq_out
);
  // ****************************************
  // storage and command state
  // ****************************************
  logic [7:0] regs_q [cclc_pkg::NUM_REGS]; // the eight setting bytes
  cclc_pkg::cclc_state_e state_q; // command or data phase
  logic [6:0] addr_q; // address latched from a write command
  logic [7:0] rd_data_q; // registered read data
  logic rd_valid_q; // one-cycle read answer
  logic [7:0] rd_mux; // current contents at the command address
  logic is_write_cmd; // command byte taken with write flag
  logic is_read_cmd; // command byte taken with read flag
  logic data_take; // data byte of a write taken
  logic [7:0] wr_mask; // writable bits at latched address

  assign is_write_cmd = clk_en_in && byte_valid_in && state_q == cclc_pkg::CCLC_ST_CMD
                        && byte_in[cclc_pkg::CMD_WRITE_BIT];
  assign is_read_cmd = clk_en_in && byte_valid_in && state_q == cclc_pkg::CCLC_ST_CMD
                       && !byte_in[cclc_pkg::CMD_WRITE_BIT];
  assign data_take = clk_en_in && byte_valid_in && state_q == cclc_pkg::CCLC_ST_WDATA;

  // ****************************************
  // command sequencer
  // ****************************************
  // a write command waits for exactly one data byte; reads answer at once
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= cclc_pkg::CCLC_ST_CMD;
      addr_q <= '0;
    end else if (clk_en_in && byte_valid_in) begin
      case (state_q)
        cclc_pkg::CCLC_ST_CMD: begin
          // low seven bits carry the address
          if (byte_in[cclc_pkg::CMD_WRITE_BIT]) begin
            addr_q <= byte_in[cclc_pkg::ADDR_W-1:0];
            state_q <= cclc_pkg::CCLC_ST_WDATA;
          end
        end
        cclc_pkg::CCLC_ST_WDATA: begin
          state_q <= cclc_pkg::CCLC_ST_CMD;
        end
        default: begin
          state_q <= cclc_pkg::CCLC_ST_CMD;
        end
      endcase
    end
  end

  // ****************************************
  // write mask
  // ****************************************
  // reserved bits of the pcm loopback byte stay zero
  always_comb begin
    if (addr_q == cclc_pkg::ADDR_PCM_ALB) begin
      wr_mask = cclc_pkg::PCM_ALB_MASK;
    end else begin
      wr_mask = cclc_pkg::FULL_MASK;
    end
  end

  // ****************************************
  // register storage
  // ****************************************
  // writes to addresses above the bank belong to other blocks and drop
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < cclc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= cclc_pkg::RST_ZERO;
      end
      regs_q[cclc_pkg::ADDR_COEF_SEL[2:0]] <= cclc_pkg::RST_COEF_SEL;
    end else if (data_take && addr_q < 7'(cclc_pkg::NUM_REGS)) begin
      regs_q[addr_q[2:0]] <= byte_in & wr_mask;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // unmapped reads answer zero so the host never hangs
  always_comb begin
    if (byte_in[cclc_pkg::ADDR_W-1:0] < 7'(cclc_pkg::NUM_REGS)) begin
      rd_mux = regs_q[byte_in[2:0]];
    end else begin
      rd_mux = cclc_pkg::RST_ZERO;
    end
  end

  // answer appears on the edge after the read command
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else if (clk_en_in) begin
      rd_valid_q <= is_read_cmd;
      if (is_read_cmd) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign rd_valid_out = rd_valid_q;
  assign rd_data_out = rd_data_q;

  // ****************************************
  // field decode to the datapath
  // ****************************************
  // software must keep impedance filter and scaling equal
  assign cfg_out.impedance_match_filter = regs_q[0][0];
  assign cfg_out.echo_cancel_filter = regs_q[0][1];
  assign cfg_out.impedance_scaling_gain = regs_q[0][2];
  assign cfg_out.hpf_enable = regs_q[0][cclc_pkg::CS_HPF];
  assign cfg_out.tx_frequency_correction = regs_q[0][4];
  assign cfg_out.tx_path_gain = regs_q[0][5];
  assign cfg_out.rx_frequency_correction = regs_q[0][6];
  assign cfg_out.rx_path_gain = regs_q[0][cclc_pkg::CS_RX_GAIN];
  assign cfg_out.onebit_digital_loopback = regs_q[1][0];
  assign cfg_out.onebit_analog_loopback = regs_q[1][1];
  assign cfg_out.pcm_digital_loopback = regs_q[1][2];
  assign cfg_out.rx_cutoff = regs_q[1][cclc_pkg::LB_CUTOFF];
  assign cfg_out.line_irq_enables = regs_q[1][7:cclc_pkg::IRQ_LSB];
  assign cfg_out.pcm_analog_loopback = regs_q[2][0];
  assign cfg_out.input_one_debounce = regs_q[3][3:0];
  assign cfg_out.input_two_debounce = regs_q[3][7:4];
  assign cfg_out.first_tone_word = {regs_q[5][3:0], regs_q[4]};
  assign cfg_out.second_tone_word = {regs_q[6], regs_q[5][7:4]};
  assign cfg_out.tone_gain_field = regs_q[7][cclc_pkg::TONE_GAIN_W-1:0];
  // tone generators start at zero crossing and stop at the peak
  assign cfg_out.first_tone_enable = regs_q[7][6];
  assign cfg_out.second_tone_enable = regs_q[7][7];

  // ****************************************
  // line pin synchronisers and debounce
  // ****************************************
  logic [3:0] sync1_q; // first stage, read only by sync2_q
  logic [3:0] sync2_q; // safe copy of the pins
  logic [3:0] filt_q; // accepted levels
  logic [3:0] irq_q; // registered interrupt events
  logic [3:0] gate; // pin may raise an interrupt now
  logic [23:0] limit [cclc_pkg::NUM_LINE]; // cycles of stability needed

  // two flops against metastability on the asynchronous pins
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en_in) begin
      sync1_q <= line_pins_in;
      sync2_q <= sync1_q;
    end
  end

  // bidir pins are not debounced; the product fits 24 bits
  assign limit[0] = '0;
  assign limit[1] = '0;
  assign limit[cclc_pkg::LINE_IN_TWO] =
    24'(cfg_out.input_two_debounce) * TWO_STEP_CYC;
  assign limit[cclc_pkg::LINE_IN_ONE] =
    24'(cfg_out.input_one_debounce) * ONE_STEP_CYC;
  // bidir pins interrupt only while configured as inputs
  assign gate = cfg_out.line_irq_enables
                & {2'b11, bidir_as_input_in[0], bidir_as_input_in[1]};

  genvar g;
  generate
    for (g = 0; g < cclc_pkg::NUM_LINE; g++) begin : g_line
      logic [23:0] cnt_q; // cycles the pin has differed
      logic accept; // take the new level this cycle
      assign accept = (sync2_q[g] != filt_q[g]) &&
                      (limit[g] == '0 || cnt_q >= limit[g] - 24'h000001);
      // a bounce back to the old level restarts the wait
      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cnt_q <= '0;
          filt_q[g] <= 1'b0;
          irq_q[g] <= 1'b0;
        end else if (clk_en_in) begin
          irq_q[g] <= accept && gate[g];
          if (accept) begin
            filt_q[g] <= sync2_q[g];
            cnt_q <= '0;
          end else if (sync2_q[g] != filt_q[g]) begin
            cnt_q <= cnt_q + 24'h000001;
          end else begin
            cnt_q <= '0;
          end
        end
      end
    end
  endgenerate

  assign line_level_out = filt_q;
  assign line_irq_out = irq_q;

  // ****************************************
  // checks
  // ****************************************
  logic coef_written_q; // coefficient byte written since reset
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      coef_written_q <= 1'b0;
    end else if (data_take && addr_q == cclc_pkg::ADDR_COEF_SEL) begin
      coef_written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_coef_write;
    data_take && addr_q == cclc_pkg::ADDR_COEF_SEL |=>
      cfg_out.impedance_match_filter == $past(byte_in[0])
      && cfg_out.impedance_scaling_gain == $past(byte_in[2]);
  endproperty
  a_coef_write: assert property (p_coef_write)
    else $error("coefficient enables not taken from write");

  property p_hpf_default;
    !coef_written_q |-> cfg_out.hpf_enable && !cfg_out.echo_cancel_filter;
  endproperty
  a_hpf_default: assert property (p_hpf_default)
    else $error("coefficient selection lost its reset value");

  property p_rx_gain;
    data_take && addr_q == cclc_pkg::ADDR_COEF_SEL && !byte_in[cclc_pkg::CS_RX_GAIN]
      |=> !cfg_out.rx_path_gain;
  endproperty
  a_rx_gain: assert property (p_rx_gain)
    else $error("receive gain stage not fixed after clear");

  property p_cutoff;
    data_take && addr_q == cclc_pkg::ADDR_LOOP_IRQ |=>
      cfg_out.rx_cutoff == $past(byte_in[3]) && cfg_out.pcm_digital_loopback == $past(byte_in[2]);
  endproperty
  a_cutoff: assert property (p_cutoff)
    else $error("cutoff or loopback not taken from write");

  property p_pcm_alb;
    data_take && addr_q == cclc_pkg::ADDR_PCM_ALB |=>
      regs_q[2] == ($past(byte_in) & cclc_pkg::PCM_ALB_MASK);
  endproperty
  a_pcm_alb: assert property (p_pcm_alb)
    else $error("pcm loopback byte holds reserved bits");

  property p_irq_gate;
    |line_irq_out |-> (line_irq_out & ~$past(gate)) == '0;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");

  property p_tone_split;
    data_take && addr_q == cclc_pkg::ADDR_TONE_MID |=>
      cfg_out.second_tone_word[3:0] == $past(byte_in[7:4])
      && cfg_out.first_tone_word[11:8] == $past(byte_in[3:0]);
  endproperty
  a_tone_split: assert property (p_tone_split)
    else $error("shared tone byte split wrongly");

  property p_read_answer;
    is_read_cmd |=> (rd_valid_out && rd_data_out == $past(rd_mux))
      ##1 (!rd_valid_out || $past(is_read_cmd));
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing or wrong");

  property p_passthrough;
    clk_en_in && cfg_out.input_one_debounce == '0 |=>
      filt_q[cclc_pkg::LINE_IN_ONE] == $past(sync2_q[cclc_pkg::LINE_IN_ONE]);
  endproperty
  a_passthrough: assert property (p_passthrough)
    else $error("zero debounce did not pass the input");

  property p_hold;
    $changed(filt_q[cclc_pkg::LINE_IN_TWO]) |->
      $past(g_line[cclc_pkg::LINE_IN_TWO].accept);
  endproperty
  a_hold: assert property (p_hold)
    else $error("input two changed before its debounce time");

  property p_loop_bits;
    data_take && addr_q == cclc_pkg::ADDR_LOOP_IRQ |=>
      {cfg_out.line_irq_enables, cfg_out.rx_cutoff, cfg_out.pcm_digital_loopback,
       cfg_out.onebit_analog_loopback, cfg_out.onebit_digital_loopback} == $past(byte_in);
  endproperty
  a_loop_bits: assert property (p_loop_bits)
    else $error("loopback byte not taken from write");

  property p_debounce_codes;
    data_take && addr_q == cclc_pkg::ADDR_DEBOUNCE |=>
      {cfg_out.input_two_debounce, cfg_out.input_one_debounce} == $past(byte_in);
  endproperty
  a_debounce_codes: assert property (p_debounce_codes)
    else $error("debounce codes not taken from write");

  property p_tone_ctl;
    data_take && addr_q == cclc_pkg::ADDR_TONE_CTL |=>
      {cfg_out.second_tone_enable, cfg_out.first_tone_enable, cfg_out.tone_gain_field}
      == $past(byte_in);
  endproperty
  a_tone_ctl: assert property (p_tone_ctl)
    else $error("tone enables or gain not taken from write");

  // run of equal samples on synchronised input one, kept apart from the filter
  logic last_one_q; // previous synchronised level of input one
  logic [23:0] run_one_q; // edges since that level last moved
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_one_q <= 1'b0;
      run_one_q <= '0;
    end else if (clk_en_in) begin
      last_one_q <= sync2_q[cclc_pkg::LINE_IN_ONE];
      // saturate so a long quiet line never wraps to a short run
      if (sync2_q[cclc_pkg::LINE_IN_ONE] != last_one_q) begin
        run_one_q <= '0;
      end else if (run_one_q != '1) begin
        run_one_q <= run_one_q + 24'h000001;
      end
    end
  end

  // a debounced change needs the new level held for the whole programmed time
  property p_one_debounce;
    $changed(filt_q[cclc_pkg::LINE_IN_ONE]) && $past(limit[cclc_pkg::LINE_IN_ONE]) != '0 |->
      $past(run_one_q) + 24'h000002 >= $past(limit[cclc_pkg::LINE_IN_ONE]);
  endproperty
  a_one_debounce: assert property (p_one_debounce)
    else $error("input one accepted before its debounce time");

  c_write: cover property (is_write_cmd ##1 data_take);
  c_masked: cover property ($changed(filt_q[1]) && !gate[1]);
  c_read: cover property (is_read_cmd ##1 rd_valid_out);
  c_irq: cover property (|line_irq_out);
  c_debounced: cover property (cfg_out.input_one_debounce != '0
                               && $changed(filt_q[cclc_pkg::LINE_IN_ONE]));
endmodule

// File: verilog/cclc_pkg.sv
// constants, types and field layout of the codec channel local config bank
package cclc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000; // master clock rate
  localparam int MS_PER_S = 1000;
  localparam int DEB_ONE_STEP_MS = 2; // input one step
  localparam int DEB_TWO_STEP_MS = 12; // input two step
  localparam int DEB_ONE_STEP_CYC = CLK_HZ / MS_PER_S * DEB_ONE_STEP_MS;
  localparam int DEB_TWO_STEP_CYC = CLK_HZ / MS_PER_S * DEB_TWO_STEP_MS;
  localparam int DEB_CNT_W = 24; // holds 15 x longest step
  // ****************************************
  // command byte and register map
  // ****************************************
  localparam int CMD_WRITE_BIT = 7; // one writes, zero reads
  localparam int ADDR_W = 7;
  localparam int NUM_REGS = 8;
  localparam logic [6:0] ADDR_COEF_SEL = 7'h00;
  localparam logic [6:0] ADDR_LOOP_IRQ = 7'h01;
  localparam logic [6:0] ADDR_PCM_ALB = 7'h02;
  localparam logic [6:0] ADDR_DEBOUNCE = 7'h03;
  localparam logic [6:0] ADDR_TONE_LOW = 7'h04;
  localparam logic [6:0] ADDR_TONE_MID = 7'h05;
  localparam logic [6:0] ADDR_TONE_HIGH = 7'h06;
  localparam logic [6:0] ADDR_TONE_CTL = 7'h07;
  localparam logic [7:0] RST_COEF_SEL = 8'h08; // high-pass on
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] PCM_ALB_MASK = 8'h01; // rest reserved
  localparam logic [7:0] FULL_MASK = 8'hff;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CS_HPF = 3;
  localparam int CS_RX_GAIN = 7;
  localparam int LB_CUTOFF = 3;
  localparam int IRQ_LSB = 4;
  localparam int NIB_W = 4;
  localparam int TONE_GAIN_W = 6;
  localparam int NUM_LINE = 4; // 0 bidir two,1 bidir one,2 in two,3 in one
  localparam int LINE_IN_TWO = 2;
  localparam int LINE_IN_ONE = 3;
  localparam int NUM_BIDIR = 2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    CCLC_ST_CMD = 2'b01,
    CCLC_ST_WDATA = 2'b10
  } cclc_state_e;
  typedef struct packed {
    logic rx_path_gain;
    logic rx_frequency_correction;
    logic tx_path_gain;
    logic tx_frequency_correction;
    logic hpf_enable;
    logic impedance_scaling_gain;
    logic echo_cancel_filter;
    logic impedance_match_filter;
    logic [3:0] line_irq_enables;
    logic rx_cutoff;
    logic pcm_digital_loopback;
    logic onebit_analog_loopback;
    logic onebit_digital_loopback;
    logic pcm_analog_loopback;
    logic [3:0] input_two_debounce;
    logic [3:0] input_one_debounce;
    logic [11:0] first_tone_word;
    logic [11:0] second_tone_word;
    logic second_tone_enable;
    logic first_tone_enable;
    logic [5:0] tone_gain_field;
  } cclc_cfg_s;
endpackage
